// [sync_serial_regs.svh]
`ifndef SYNC_SERIAL_REGS_SVH
`define SYNC_SERIAL_REGS_SVH

// Register byte offsets on the APB.
`define OFS_BAUD_CONTROL 8'h00
`define OFS_RECEIVE_DATA 8'h04
`define OFS_RECEIVE_STATUS_CONTROL 8'h08
`define OFS_BAUD_DIVISOR_LOW 8'h0c
`define OFS_BAUD_DIVISOR_HIGH 8'h10
`define OFS_TRANSMIT_STATUS_CONTROL 8'h14
`define OFS_TRANSMIT_HOLDING 8'h18
`define OFS_INTERRUPT_CONTROL 8'h1c

// Receive status and control fields.
`define RSC_PORT_EN 7
`define RSC_RX_NINE 6
`define RSC_SINGLE 5
`define RSC_CONT 4
`define RSC_ADDR_DET 3
`define RSC_FRAME_ERR 2
`define RSC_OVERRUN 1
`define RSC_RX_NINTH 0

// Transmit status and control fields.
`define TSC_CLK_SRC 7
`define TSC_TX_NINE 6
`define TSC_TX_EN 5
`define TSC_SYNC 4
`define TSC_HIGH_BAUD 2
`define TSC_SHIFT_EMPTY 1
`define TSC_TX_NINTH 0

// Baud control fields.
`define BDC_RX_IDLE 6
`define BDC_CLK_POL 4
`define BDC_WIDE_DIV 3

// Interrupt control fields.
`define ICT_RX_IE 0
`define ICT_TX_IE 1
`define ICT_PERIPH_IE 2
`define ICT_GLOBAL_IE 3
`define ICT_SLEEP 4
`define ICT_RX_FLAG 5
`define ICT_TX_FLAG 6

// Reset values, character sizes and receive buffer depth.
`define RST_BYTE 8'h00
`define CHAR_BITS_8 4'h8
`define CHAR_BITS_9 4'h9
`define RX_DEPTH 2'h2

`endif

// [sync_serial_pkg.sv]
package sync_serial_pkg;

  // Transmit engine states.
  typedef enum logic [1:0] {
    TX_IDLE = 2'b01,
    TX_SHIFT = 2'b10
  } tx_state_t;

endpackage : sync_serial_pkg

// [sync_serial.sv]
// Implementation choices: the address map and register access over APB.
`timescale 1ns/1ps
`include "sync_serial_regs.svh"

module sync_serial #(
  parameter int ADDR_W = 8
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic nrst,
  // APB slave.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Link pins, enables active low.
  input wire logic clock_line_in,
  output logic clock_line_out,
  output logic clock_line_oe_n,
  input wire logic data_line_in,
  output logic data_line_out,
  output logic data_line_oe_n,
  // Processor side.
  output logic wake_request,
  output logic interrupt_request
);

  if (ADDR_W < 5) begin : g_check
    $error("ADDR_W must be at least 5");
  end

  // Configuration registers.
  logic [7:0] rsc, tsc, bdc, div_lo, div_hi, ict;
  logic [7:0] next_rsc, next_tsc, next_bdc, next_div_lo, next_div_hi, next_ict;
  // Pin synchronisers and filtered levels.
  logic [2:0] ck_s, dt_s;
  logic ck_lvl, dt_lvl, ck_prev, next_ck_lvl, next_dt_lvl;
  // Master clock generator.
  logic [15:0] mcnt, next_mcnt, divisor;
  logic mphase, next_mphase, next_clk_out;
  // Receiver.
  logic [8:0] receive_shift_register, next_rsr;
  logic [3:0] rcnt, next_rcnt;
  logic [8:0] rx_mem [2];
  logic [8:0] next_mem0, next_mem1;
  logic rx_head, next_head, overrun_error_flag, next_overrun_error_flag, overrun_error_flag_cont, next_overrun_error_flag_cont;
  logic [1:0] rx_count, next_count;
  // Transmitter.
  sync_serial_pkg::tx_state_t tx_state, next_tx_state;
  logic [8:0] hold, next_hold, transmit_shift_register, next_tsr;
  logic hold_full, next_hold_full, dout, next_dout;
  logic [3:0] tcnt, next_tcnt;
  logic [31:0] next_prdata;
  logic next_wake, next_irq;

  // Bus decode; every access completes with no wait state.
  logic acc, wr, rd, mapped;
  logic [7:0] addr8;
  assign addr8 = 8'(paddr);
  assign acc = psel & penable;
  assign wr = acc & pwrite;
  assign rd = acc & !pwrite;
  assign mapped = (paddr[1:0] == 2'b00) && (addr8 <= `OFS_INTERRUPT_CONTROL) &&
                  (ADDR_W == 8 || (paddr >> 8) == '0);
  assign pready = 1'b1;
  assign pslverr = acc & !mapped;
  logic wr_rsc, wr_tsc, wr_hold, rd_data;
  assign wr_rsc = wr & mapped & (addr8 == `OFS_RECEIVE_STATUS_CONTROL);
  assign wr_tsc = wr & mapped & (addr8 == `OFS_TRANSMIT_STATUS_CONTROL);
  assign wr_hold = wr & mapped & (addr8 == `OFS_TRANSMIT_HOLDING);
  assign rd_data = rd & mapped & (addr8 == `OFS_RECEIVE_DATA);

  // Mode decode.
  logic enabled, master, recv_req, rx_mode, tx_mode, receive_complete_flag, transmit_buffer_empty_flag;
  logic [3:0] rx_nbits, tx_nbits;
  assign enabled = rsc[`RSC_PORT_EN] & tsc[`TSC_SYNC];
  assign master = tsc[`TSC_CLK_SRC];
  // A slave only looks at the continuous enable, the single one is ignored.
  assign recv_req = master ? (rsc[`RSC_SINGLE] | rsc[`RSC_CONT])
                           : rsc[`RSC_CONT];
  assign rx_mode = enabled & recv_req;
  assign tx_mode = enabled & !recv_req;
  assign rx_nbits = rsc[`RSC_RX_NINE] ? `CHAR_BITS_9 : `CHAR_BITS_8;
  assign tx_nbits = tsc[`TSC_TX_NINE] ? `CHAR_BITS_9 : `CHAR_BITS_8;
  assign receive_complete_flag = (rx_count != 2'h0);
  assign transmit_buffer_empty_flag = !hold_full;

  // Clock edges from the generator in master mode, from the pin as slave.
  logic m_run, m_tick, s_edge, lead, trail;
  assign divisor = bdc[`BDC_WIDE_DIV] ? {div_hi, div_lo} : {8'h00, div_lo};
  assign m_run = enabled & master &
                 ((rx_mode & !overrun_error_flag) | (tx_state == sync_serial_pkg::TX_SHIFT));
  assign m_tick = m_run & (mcnt == divisor);
  assign s_edge = enabled & !master & (ck_lvl != ck_prev);
  assign lead = master ? (m_tick & !mphase) : (s_edge & (ck_lvl != bdc[`BDC_CLK_POL]));
  assign trail = master ? (m_tick & mphase) : (s_edge & (ck_lvl == bdc[`BDC_CLK_POL]));

  // Receive completion and buffer pop.
  logic rx_take, rx_done, pop;
  assign rx_take = rx_mode & !overrun_error_flag & trail;
  assign rx_done = rx_take & (rcnt == rx_nbits - 4'h1);
  assign pop = rd_data & receive_complete_flag;

  // Pins: the slave releases the clock line, the receiver the data line.
  assign clock_line_oe_n = !(enabled & master);
  assign data_line_oe_n = !(tx_mode & tsc[`TSC_TX_EN]);
  assign data_line_out = dout;

  // A pin level counts once the second and third stages agree.
  always_comb begin
    next_ck_lvl = (ck_s[1] == ck_s[2]) ? ck_s[2] : ck_lvl;
    next_dt_lvl = (dt_s[1] == dt_s[2]) ? dt_s[2] : dt_lvl;
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ck_s <= 3'h0;
      dt_s <= 3'h0;
      ck_lvl <= 1'b0;
      dt_lvl <= 1'b0;
      ck_prev <= 1'b0;
    end else begin
      ck_s <= {ck_s[1:0], clock_line_in};
      dt_s <= {dt_s[1:0], data_line_in};
      ck_lvl <= next_ck_lvl;
      dt_lvl <= next_dt_lvl;
      ck_prev <= ck_lvl;
    end
  end

  // Software writes; in master mode the single enable drops by itself after one character.
  always_comb begin
    next_rsc = rsc;
    next_tsc = tsc;
    next_bdc = bdc;
    next_div_lo = div_lo;
    next_div_hi = div_hi;
    next_ict = ict;
    if (rx_done && master) begin
      next_rsc[`RSC_SINGLE] = 1'b0;
    end
    if (wr && mapped) begin
      unique case (addr8)
        `OFS_BAUD_CONTROL: next_bdc = pwdata[7:0] & 8'h18;
        `OFS_RECEIVE_STATUS_CONTROL: next_rsc = pwdata[7:0] & 8'hf8;
        `OFS_BAUD_DIVISOR_LOW: next_div_lo = pwdata[7:0];
        `OFS_BAUD_DIVISOR_HIGH: next_div_hi = pwdata[7:0];
        `OFS_TRANSMIT_STATUS_CONTROL: next_tsc = pwdata[7:0] & 8'hf5;
        `OFS_INTERRUPT_CONTROL: next_ict = pwdata[7:0] & 8'h1f;
        default: next_ict = ict;
      endcase
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rsc <= `RST_BYTE;
      tsc <= `RST_BYTE;
      bdc <= `RST_BYTE;
      div_lo <= `RST_BYTE;
      div_hi <= `RST_BYTE;
      ict <= `RST_BYTE;
    end else begin
      rsc <= next_rsc;
      tsc <= next_tsc;
      bdc <= next_bdc;
      div_lo <= next_div_lo;
      div_hi <= next_div_hi;
      ict <= next_ict;
    end
  end

  // Master clock: a half bit is divisor plus one system cycles.
  always_comb begin
    next_mcnt = 16'h0000;
    next_mphase = 1'b0;
    if (m_run) begin
      next_mphase = m_tick ? !mphase : mphase;
      next_mcnt = m_tick ? 16'h0000 : mcnt + 16'h0001;
    end
    next_clk_out = bdc[`BDC_CLK_POL] ^ next_mphase;
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      mcnt <= 16'h0000;
      mphase <= 1'b0;
      clock_line_out <= 1'b0;
    end else begin
      mcnt <= next_mcnt;
      mphase <= next_mphase;
      clock_line_out <= next_clk_out;
    end
  end

  // Receiver and two-entry buffer. Dropping the receive request discards
  // a partial character, and a disabled port loses everything.
  always_comb begin
    next_rsr = receive_shift_register;
    next_rcnt = rcnt;
    next_mem0 = rx_mem[0];
    next_mem1 = rx_mem[1];
    next_head = rx_head;
    next_count = rx_count;
    next_overrun_error_flag = overrun_error_flag;
    next_overrun_error_flag_cont = overrun_error_flag_cont;
    if (!rx_mode) begin
      next_rcnt = 4'h0;
    end else if (rx_take) begin
      next_rsr = {dt_lvl, receive_shift_register[8:1]};
      next_rcnt = rx_done ? 4'h0 : rcnt + 4'h1;
    end
    if (pop) begin
      next_head = !rx_head;
      next_count = rx_count - 2'h1;
    end
    if (rx_done) begin
      if (rx_count == `RX_DEPTH) begin
        next_overrun_error_flag = 1'b1;
        next_overrun_error_flag_cont = rsc[`RSC_CONT];
      end else begin
        // Nine-bit characters keep the ninth bit on top.
        if ((rx_head ^ rx_count[0]) == 1'b0) begin
          next_mem0 = rx_nbits == `CHAR_BITS_9 ? next_rsr : {1'b0, next_rsr[8:1]};
        end else begin
          next_mem1 = rx_nbits == `CHAR_BITS_9 ? next_rsr : {1'b0, next_rsr[8:1]};
        end
        next_count = next_count + 2'h1;
      end
    end else if (overrun_error_flag && (overrun_error_flag_cont ? !rsc[`RSC_CONT] : rd_data)) begin
      next_overrun_error_flag = 1'b0;
    end
    if (!enabled) begin
      next_rcnt = 4'h0;
      next_head = 1'b0;
      next_count = 2'h0;
      next_overrun_error_flag = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      receive_shift_register <= 9'h000;
      rcnt <= 4'h0;
      rx_mem[0] <= 9'h000;
      rx_mem[1] <= 9'h000;
      rx_head <= 1'b0;
      rx_count <= 2'h0;
      overrun_error_flag <= 1'b0;
      overrun_error_flag_cont <= 1'b0;
    end else begin
      receive_shift_register <= next_rsr;
      rcnt <= next_rcnt;
      rx_mem[0] <= next_mem0;
      rx_mem[1] <= next_mem1;
      rx_head <= next_head;
      rx_count <= next_count;
      overrun_error_flag <= next_overrun_error_flag;
      overrun_error_flag_cont <= next_overrun_error_flag_cont;
    end
  end

  // Transmitter: holding register feeds the shift register as soon as it
  // is free; a write in the cycle of the transfer is kept, not lost.
  always_comb begin
    next_tx_state = tx_state;
    next_hold = hold;
    next_hold_full = hold_full;
    next_tsr = transmit_shift_register;
    next_tcnt = tcnt;
    next_dout = dout;
    unique case (tx_state)
      sync_serial_pkg::TX_IDLE: begin
        if (hold_full && tx_mode && tsc[`TSC_TX_EN]) begin
          next_tsr = hold;
          next_hold_full = 1'b0;
          next_tcnt = 4'h0;
          next_tx_state = sync_serial_pkg::TX_SHIFT;
        end
      end
      sync_serial_pkg::TX_SHIFT: begin
        if (lead && tcnt != tx_nbits) begin
          next_dout = transmit_shift_register[0];
          next_tsr = {1'b0, transmit_shift_register[8:1]};
          next_tcnt = tcnt + 4'h1;
        end else if (trail && tcnt == tx_nbits) begin
          next_tx_state = sync_serial_pkg::TX_IDLE;
        end
      end
    endcase
    if (wr_hold) begin
      next_hold = {tsc[`TSC_TX_NINTH], pwdata[7:0]};
      next_hold_full = 1'b1;
    end
    if (!tx_mode || !tsc[`TSC_TX_EN]) begin
      next_tx_state = sync_serial_pkg::TX_IDLE;
      next_hold_full = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      tx_state <= sync_serial_pkg::TX_IDLE;
      hold <= 9'h000;
      hold_full <= 1'b0;
      transmit_shift_register <= 9'h000;
      tcnt <= 4'h0;
      dout <= 1'b0;
    end else begin
      tx_state <= next_tx_state;
      hold <= next_hold;
      hold_full <= next_hold_full;
      transmit_shift_register <= next_tsr;
      tcnt <= next_tcnt;
      dout <= next_dout;
    end
  end

  // Read data is captured in the setup phase so the pop cannot disturb it.
  always_comb begin
    next_prdata = prdata;
    if (psel && !penable) begin
      next_prdata = 32'h0000_0000;
      unique case (addr8)
        `OFS_BAUD_CONTROL: next_prdata[7:0] = bdc | {1'b0, !rx_mode, 6'h00};
        `OFS_RECEIVE_DATA: next_prdata[7:0] = rx_mem[rx_head][7:0];
        `OFS_RECEIVE_STATUS_CONTROL: begin
          next_prdata[7:0] = rsc;
          next_prdata[`RSC_OVERRUN] = overrun_error_flag;
          next_prdata[`RSC_RX_NINTH] = receive_complete_flag & rx_mem[rx_head][8];
        end
        `OFS_BAUD_DIVISOR_LOW: next_prdata[7:0] = div_lo;
        `OFS_BAUD_DIVISOR_HIGH: next_prdata[7:0] = div_hi;
        `OFS_TRANSMIT_STATUS_CONTROL: begin
          next_prdata[7:0] = tsc;
          next_prdata[`TSC_SHIFT_EMPTY] = (tx_state == sync_serial_pkg::TX_IDLE);
        end
        `OFS_INTERRUPT_CONTROL: next_prdata[7:0] = ict | {1'b0, transmit_buffer_empty_flag, receive_complete_flag, 5'h00};
        default: next_prdata = 32'h0000_0000;
      endcase
    end
  end

  // Wake in sleep needs the peripheral enable; the vector also needs global.
  always_comb begin
    logic cause;
    cause = ict[`ICT_PERIPH_IE] &
            ((transmit_buffer_empty_flag & ict[`ICT_TX_IE]) | (receive_complete_flag & ict[`ICT_RX_IE]));
    next_wake = cause & ict[`ICT_SLEEP];
    next_irq = cause & ict[`ICT_GLOBAL_IE];
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      prdata <= 32'h0000_0000;
      wake_request <= 1'b0;
      interrupt_request <= 1'b0;
    end else begin
      prdata <= next_prdata;
      wake_request <= next_wake;
      interrupt_request <= next_irq;
    end
  end

endmodule : sync_serial

// [sync_serial_monitor.sv]
`timescale 1ns/1ps
`include "sync_serial_regs.svh"

// Pin-level watcher. Mode bits are shadowed from APB writes, since only the pins are visible.
module sync_serial_monitor #(
  parameter int ADDR_W = 8
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic nrst,
  // APB slave.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Link pins.
  input wire logic clock_line_in,
  input wire logic clock_line_out,
  input wire logic clock_line_oe_n,
  input wire logic data_line_in,
  input wire logic data_line_out,
  input wire logic data_line_oe_n,
  // Processor side.
  input wire logic wake_request,
  input wire logic interrupt_request
);
  logic [7:0] bdc;
  logic [7:0] rsc;
  logic [7:0] lo;
  logic [7:0] tsc;
  logic [7:0] ict;
  logic [8:0] run;
  logic wr;
  logic slave;
  logic master;
  logic no_wake;
  logic no_ie;

  default clocking mon_cb @(posedge clk);
  endclocking
  default disable iff (!nrst);

  // Modes decoded from the shadows.
  assign wr = psel && penable && pwrite && pready;
  assign slave = rsc[`RSC_PORT_EN] && tsc[`TSC_SYNC] && !tsc[`TSC_CLK_SRC];
  assign master = rsc[`RSC_PORT_EN] && tsc[`TSC_SYNC] && tsc[`TSC_CLK_SRC];
  assign no_wake = !(ict[`ICT_SLEEP] && ict[`ICT_PERIPH_IE]);
  assign no_ie = !ict[`ICT_RX_IE] && !ict[`ICT_TX_IE];

  // Shadows keep all eight written bits unmasked and miss the hardware clear of the single enable, so they can drift from the design.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      bdc <= 8'h00;
      rsc <= 8'h00;
      lo <= 8'h00;
      tsc <= 8'h00;
      ict <= 8'h00;
      run <= 9'h000;
    end else begin
      if (wr && paddr == `OFS_BAUD_CONTROL) bdc <= pwdata[7:0];
      if (wr && paddr == `OFS_RECEIVE_STATUS_CONTROL) rsc <= pwdata[7:0];
      if (wr && paddr == `OFS_BAUD_DIVISOR_LOW) lo <= pwdata[7:0];
      if (wr && paddr == `OFS_TRANSMIT_STATUS_CONTROL) tsc <= pwdata[7:0];
      if (wr && paddr == `OFS_INTERRUPT_CONTROL) ict <= pwdata[7:0];
      run <= $changed(clock_line_out) ? 9'h001 : run + {8'h00, run != 9'h1ff};
    end
  end

  // Output relations; the sample after a mode write is skipped for registered pins.
  AST_SLAVE_CLOCK_IN: assert property (slave && $past(slave) |-> clock_line_oe_n)
    else $error("clock pin driven in slave mode");
  AST_RX_NO_DRIVE: assert property (rsc[`RSC_CONT] && $past(rsc[`RSC_CONT]) |-> data_line_oe_n)
    else $error("data pin driven in receive mode");
  AST_IRQ_GATED: assert property (!ict[`ICT_GLOBAL_IE] && !$past(ict[`ICT_GLOBAL_IE]) |-> !interrupt_request)
    else $error("interrupt without global enable");
  AST_WAKE_GATED: assert property (no_wake && $past(no_wake) |-> !wake_request)
    else $error("wake without sleep and peripheral enable");
  AST_IE_GATED: assert property (no_ie && $past(no_ie) |-> !wake_request && !interrupt_request)
    else $error("request with both enables clear");
  AST_HALF_PERIOD: assert property (master && !bdc[`BDC_WIDE_DIV] && !clock_line_oe_n && $changed(clock_line_out) |-> run > {1'b0, lo})
    else $error("master clock half period too short");
  AST_READ_UPPER: assert property (psel && penable && !pwrite |-> prdata[31:8] == 24'h00_0000)
    else $error("read data above bit 7 not zero");
  AST_OFF_NO_CLOCK: assert property (!rsc[`RSC_PORT_EN] && !$past(rsc[`RSC_PORT_EN]) |-> clock_line_oe_n)
    else $error("clock pin driven with port disabled");
  AST_SYNC_DELAY: assert property (slave && $changed(clock_line_in) |=> $stable(data_line_out) [*2])
    else $error("data moved before clock was synchronised");

  // Main scenarios reached.
  COV_WAKE: cover property ($rose(wake_request));
  COV_IRQ: cover property ($rose(interrupt_request));
  COV_MASTER: cover property (master && $rose(clock_line_out));
endmodule : sync_serial_monitor

bind sync_serial sync_serial_monitor #(.ADDR_W(ADDR_W)) mon (.clk, .nrst, .psel, .penable,
  .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .clock_line_in, .clock_line_out,
  .clock_line_oe_n, .data_line_in, .data_line_out, .data_line_oe_n, .wake_request,
  .interrupt_request);

// [sync_serial_peer.sv]
`timescale 1ns/1ps

// Peer on the shared link. As master it clocks 125 ns bits with the clock idle low.
module sync_serial_peer (
  // Resolved link wires.
  input wire logic clk_w,
  input wire logic dat_w,
  // Peer drivers.
  output logic pk,
  output logic pd
);
  logic [8:0] sbuf;
  logic armed;
  int sidx;

  // Clock stands still low outside frames.
  initial begin
    pk = 1'b0;
    pd = 1'b1;
    armed = 1'b0;
    sidx = 0;
  end

  // One clock per bit: data set at the leading edge, read at the trailing edge.
  task xfer(input logic [8:0] tx, input int n, output logic [8:0] rx);
    rx = 9'h000;
    #3;
    for (int i = 0; i < n; i++) begin
      pk = 1'b1;
      pd = tx[i];
      #62.5;
      pk = 1'b0;
      rx[i] = dat_w;
      #62.5;
    end
    // A released line shows the inverse of its last bit, so stale data never passes.
    pd = ~pd;
  endtask : xfer

  // Load a character to hand out as a clock slave.
  task arm(input logic [8:0] v);
    sbuf = v;
    sidx = 0;
    armed = 1'b1;
  endtask : arm

  // Slave side: next bit on each leading edge of the device's clock.
  always @(posedge clk_w) begin
    if (armed && sidx < 9) begin
      pd <= sbuf[sidx];
      sidx <= sidx + 1;
    end
  end
endmodule : sync_serial_peer

// [sync_serial_tb.sv]
`timescale 1ns/1ps
`include "sync_serial_regs.svh"

// Register traffic over APB plus a peer on the link.
module sync_serial_tb;
  localparam logic [7:0] rsc = `OFS_RECEIVE_STATUS_CONTROL;
  localparam logic [7:0] tsc = `OFS_TRANSMIT_STATUS_CONTROL;
  localparam logic [7:0] ict = `OFS_INTERRUPT_CONTROL;
  localparam logic [7:0] rxd = `OFS_RECEIVE_DATA;
  localparam logic [7:0] hold = `OFS_TRANSMIT_HOLDING;
  logic clk, nrst, psel, penable, pwrite, pk, pd, clk_w, dat_w, err;
  logic pready, pslverr, clock_line_out, clock_line_oe_n, data_line_out, data_line_oe_n;
  logic wake_request, interrupt_request;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, r;
  logic [8:0] got;
  int errors, samples_checked;

  // Each pin resolves to whichever party has its driver on.
  assign clk_w = clock_line_oe_n ? pk : clock_line_out;
  assign dat_w = data_line_oe_n ? pd : data_line_out;

  sync_serial dut (.clk, .nrst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .clock_line_in(clk_w), .clock_line_out, .clock_line_oe_n, .data_line_in(dat_w),
    .data_line_out, .data_line_oe_n, .wake_request, .interrupt_request);
  sync_serial_peer peer (.clk_w, .dat_w, .pk, .pd);

  // System clock.
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // One transfer; the request holds until pready is seen high at a rising edge.
  task apb(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h00_0000, d};
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    r = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task chk(input string n, input logic [31:0] s, input logic [31:0] e);
    samples_checked++;
    if (s !== e) begin
      errors++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask : chk

  task rd(input logic [7:0] a, m, input string n, input logic [31:0] e);
    apb(1'b0, a, 8'h00);
    chk(n, r & {24'hFF_FFFF, m}, e);
  endtask : rd

  task wr(input logic [7:0] a, d);
    apb(1'b1, a, d);
  endtask : wr

  // The wait lets the synchroniser and flag registers settle after the frame.
  task send(input logic [8:0] t, input int n);
    peer.xfer(t, n, got);
    repeat (10) @(posedge clk);
  endtask : send

  task finish_test();
    if (errors == 0 && samples_checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : finish_test

  // Watchdog well beyond the expected run of some one thousand cycles.
  initial begin
    #100_000;
    errors++;
    finish_test();
  end

  // Main sequence.
  initial begin
    nrst = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    repeat (20) @(posedge clk);
    nrst <= 1'b1;
    rd(rsc, 8'hFF, "rsc_reset", `RST_BYTE);
    rd(hold, 8'hFF, "hold_reads_zero", 32'h0000_0000);
    rd(8'h20, 8'hFF, "unmapped", 32'h0000_0000);
    chk("unmapped_err", {31'h0, err}, 32'h1);
    // Slave receive: two characters fill the buffer and a third overruns.
    wr(tsc, 8'h10);
    wr(ict, 8'h01);
    wr(rsc, 8'hB0);
    send(9'h0A5, 8);
    send(9'h03C, 8);
    send(9'h00F, 8);
    rd(rsc, 8'h03, "overrun", 32'h2);
    rd(ict, 8'hBF, "rx_flag", 32'h21);
    rd(rxd, 8'hFF, "first", 32'hA5);
    rd(rxd, 8'hFF, "second", 32'h3C);
    rd(ict, 8'hBF, "rx_flag_clear", 32'h01);
    wr(rsc, 8'h80);
    rd(rsc, 8'h03, "overrun_clear", 32'h0);
    // Nine-bit character received asleep with every enable but the transmit one set.
    wr(ict, 8'h1D);
    wr(rsc, 8'hD0);
    send(9'h1C3, 9);
    chk("rx_wake", {31'h0, wake_request}, 32'h1);
    chk("rx_vector", {31'h0, interrupt_request}, 32'h1);
    rd(rsc, 8'h01, "ninth_bit", 32'h1);
    rd(rxd, 8'hFF, "low_eight", 32'hC3);
    send(9'h0AA, 9);
    wr(rsc, 8'h50);
    rd(ict, 8'h20, "flushed", 32'h0);
    // Slave transmit: the second character waits in holding while asleep.
    wr(ict, 8'h16);
    wr(rsc, 8'h80);
    wr(tsc, 8'h30);
    wr(hold, 8'h96);
    wr(hold, 8'h69);
    rd(ict, 8'h40, "tx_flag_held", 32'h0);
    chk("tx_drive", {31'h0, data_line_oe_n}, 32'h0);
    send(9'h000, 8);
    chk("first_out", {23'h0, got}, 32'h96);
    chk("tx_wake", {31'h0, wake_request}, 32'h1);
    chk("tx_no_vector", {31'h0, interrupt_request}, 32'h0);
    send(9'h000, 8);
    chk("second_out", {23'h0, got}, 32'h69);
    // Master single receive. The data pin passes a three-stage synchroniser and a level filter,
    // so a half bit must last well over four cycles: divisor 7 gives eight.
    wr(ict, 8'h00);
    wr(`OFS_BAUD_DIVISOR_LOW, 8'h07);
    wr(tsc, 8'h90);
    rd(rsc, 8'h30, "rx_enables_clear", 32'h0);
    peer.arm(9'h0D2);
    wr(rsc, 8'hA0);
    r = 32'h0000_0000;
    for (int i = 0; i < 100 && r[5] !== 1'b1; i++) apb(1'b0, ict, 8'h00);
    rd(rsc, 8'h20, "single_cleared", 32'h0);
    rd(rxd, 8'hFF, "master_char", 32'hD2);
    chk("clocks", peer.sidx, 32'h8);
    wr(rsc, 8'h00);
    repeat (3) @(posedge clk);
    chk("clock_released", {31'h0, clock_line_oe_n}, 32'h1);
    finish_test();
  end
endmodule : sync_serial_tb
